//--- hw/ua_pkg.sv
// shared constants, states and state record for the address-detect and wake block
package ua_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL1 = 8'h00;
    localparam logic [7:0] OFF_CTRL2 = 8'h04;
    localparam logic [7:0] OFF_IRQEN = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_DATA = 8'h10;
    localparam logic [7:0] OFF_BAUD = 8'h14;
    localparam logic [7:0] OFF_ISTAT = 8'h18;
    localparam logic [7:0] OFF_IMASK = 8'h1c;
    // uart_ctrl1 fields
    localparam int C1_UART_EN = 0;
    localparam int C1_MODE_SEL = 1;
    localparam int C1_PARITY_EN = 2;
    localparam int C1_NINE_BIT = 3;
    // uart_ctrl2 fields
    localparam int C2_ADDR_DET = 0;
    localparam int C2_WAKE_EN = 1;
    localparam int C2_RX_EN = 2;
    localparam int C2_RX_IRQ = 3;
    // interrupt enable fields
    localparam int IE_SERIAL = 0;
    localparam int IE_GLOBAL = 1;
    // uart_status_reg fields
    localparam int ST_AVAIL = 0;
    localparam int ST_RX_IDLE = 1;
    localparam int ST_TX_BUSY = 2;
    localparam int ST_STARTUP = 3;
    localparam int ST_ADDR = 4;
    // sticky event status and mask fields
    localparam int IS_RX = 0;
    localparam int IS_WAKE = 1;
    // reset values
    localparam logic [7:0] BAUD_RST = 8'h09;
    // start-up interval after a wake-up
    localparam int CLK_NS = 50;
    localparam int STARTUP_NS = 1000;
    localparam logic [7:0] STARTUP_CYC = 8'((STARTUP_NS + CLK_NS - 1) / CLK_NS);

    typedef enum logic [1:0] {UA_RX_IDLE, UA_RX_START, UA_RX_BITS, UA_RX_STOP} ua_rx_t;
    typedef enum logic [0:0] {UA_TX_IDLE, UA_TX_SEND} ua_tx_t;

    typedef struct packed {
        logic [3:0] ctrl1;
        logic [3:0] ctrl2;
        logic [1:0] irq_en;
        logic [7:0] baud;
        logic [8:0] rx_data;
        logic rx_avail;
        logic rx_addr;
        logic [1:0] istat;
        logic [1:0] imask;
        ua_rx_t rx_st;
        logic [7:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [9:0] rx_shift;
        ua_tx_t tx_st;
        logic [7:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [11:0] tx_shift;
        logic tx_pin;
        logic rx_s1;
        logic rx_s2;
        logic rx_s3;
        logic ck_s1;
        logic ck_s2;
        logic ck_s3;
        logic wake_seen;
        logic [7:0] start_cnt;
        logic wake_req;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ua_state_t;
endpackage

//--- hw/ua_addr_wake.sv
// uart receive qualification, power-down pause and rx pin wake-up with apb registers
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns

// Contract
// [RULE_01] address mode: interrupt only when top bit high
// [RULE_02] top bit is ninth or eighth by width
// [RULE_03] top bit high marks word as address
// [RULE_04] no address mode: interrupt on every word
// [RULE_05] interrupt needs serial and global enables
// [RULE_06] software clears parity when address mode on
// [RULE_07] uart clock off pauses all activity
// [RULE_08] idle or sleep suspends reception in place
// [RULE_09] sleep leaves all registers unchanged
// [RULE_10] software finishes transfers before sleeping
// [RULE_11] armed and clock off: rx fall wakes
// [RULE_12] rx activity during start-up is discarded
// [RULE_13] enables clear: wake only, no interrupt
// [RULE_14] interrupt withheld until start-up elapses
// [RULE_15] receive-available flag set while data unread
// [RULE_16] address and wake share serial interrupt
// [RULE_17] wake edge detected without uart clock
module ua_addr_wake (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_pin,
    input wire logic uart_clk_on,
    input wire logic cpu_sleep,
    output logic tx_pin,
    output logic irq,
    output logic wake_req
);
    ua_pkg::ua_state_t st;
    ua_pkg::ua_state_t nx;
    logic run;
    logic word_done;
    logic rx_top;
    logic rx_fall;
    logic wake_arm;
    logic acc;
    logic [3:0] nd;
    logic [3:0] nbits;
    logic [8:0] wd9;
    logic [8:0] rd9;
    logic [11:0] frame;

    // all next-state logic
    always_comb begin
        nx = st;
        word_done = 1'b0;
        // two-flop synchronisers, third stage only for edge detection
        nx.rx_s1 = rx_pin;
        nx.rx_s2 = st.rx_s1;
        nx.rx_s3 = st.rx_s2;
        nx.ck_s1 = uart_clk_on;
        nx.ck_s2 = st.ck_s1;
        nx.ck_s3 = st.ck_s2;
        // [RULE_07] pause when clock off
        // [RULE_08] sleep also freezes the engines
        run = st.ck_s2 && !cpu_sleep;
        nd = st.ctrl1[ua_pkg::C1_NINE_BIT] ? 4'h9 : 4'h8;
        nbits = nd + {3'h0, st.ctrl1[ua_pkg::C1_PARITY_EN]};
        // [RULE_02] pick ninth or eighth bit
        rx_top = st.ctrl1[ua_pkg::C1_NINE_BIT] ? st.rx_shift[8] : st.rx_shift[7];
        rd9 = st.ctrl1[ua_pkg::C1_NINE_BIT] ? st.rx_shift[8:0] : {1'b0, st.rx_shift[7:0]};
        // [RULE_17] edge seen on bus clock, independent of uart clock
        rx_fall = st.rx_s3 && !st.rx_s2;
        // [RULE_11] wake arming terms
        wake_arm = !st.ck_s2 && st.ctrl2[ua_pkg::C2_WAKE_EN]
            && st.ctrl1[ua_pkg::C1_MODE_SEL] && st.ctrl1[ua_pkg::C1_UART_EN]
            && st.ctrl2[ua_pkg::C2_RX_EN] && st.ctrl2[ua_pkg::C2_RX_IRQ];
        // transmit frame: start, data lsb first, optional even parity, stop ones
        wd9 = st.ctrl1[ua_pkg::C1_NINE_BIT] ? pwdata[8:0] : {1'b0, pwdata[7:0]};
        frame = 12'hfff;
        frame[0] = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(nd)) begin
                frame[i + 1] = wd9[i];
            end
        end
        if (st.ctrl1[ua_pkg::C1_PARITY_EN]) begin
            frame[nd + 4'h1] = ^wd9;
        end
        // apb slave, one wait state; handled first so hardware sets win
        acc = psel && penable && !st.pready;
        nx.pready = acc;
        nx.pslverr = 1'b0;
        if (acc) begin
            nx.prdata = 32'h0000_0000;
            // [RULE_09] only bus writes and receive or wake events change registers, never sleep
            case (paddr)
                ua_pkg::OFF_CTRL1: begin
                    nx.prdata[3:0] = st.ctrl1;
                    if (pwrite) begin
                        nx.ctrl1 = pwdata[3:0];
                    end
                end
                ua_pkg::OFF_CTRL2: begin
                    nx.prdata[3:0] = st.ctrl2;
                    if (pwrite) begin
                        nx.ctrl2 = pwdata[3:0];
                    end
                end
                ua_pkg::OFF_IRQEN: begin
                    nx.prdata[1:0] = st.irq_en;
                    if (pwrite) begin
                        nx.irq_en = pwdata[1:0];
                    end
                end
                ua_pkg::OFF_STATUS: begin
                    nx.prdata[ua_pkg::ST_AVAIL] = st.rx_avail;
                    nx.prdata[ua_pkg::ST_RX_IDLE] = st.rx_st == ua_pkg::UA_RX_IDLE;
                    nx.prdata[ua_pkg::ST_TX_BUSY] = st.tx_st == ua_pkg::UA_TX_SEND;
                    nx.prdata[ua_pkg::ST_STARTUP] = st.start_cnt != 8'h00;
                    nx.prdata[ua_pkg::ST_ADDR] = st.rx_addr;
                end
                ua_pkg::OFF_DATA: begin
                    nx.prdata[8:0] = st.rx_data;
                    if (!pwrite) begin
                        nx.rx_avail = 1'b0;
                    end else if (run && st.tx_st == ua_pkg::UA_TX_IDLE
                            && st.ctrl1[ua_pkg::C1_UART_EN]) begin
                        nx.tx_st = ua_pkg::UA_TX_SEND;
                        nx.tx_pin = frame[0];
                        nx.tx_shift = {1'b1, frame[11:1]};
                        nx.tx_bit = nbits + 4'h1;
                        nx.tx_cnt = st.baud;
                    end
                end
                ua_pkg::OFF_BAUD: begin
                    nx.prdata[7:0] = st.baud;
                    if (pwrite) begin
                        nx.baud = pwdata[7:0];
                    end
                end
                ua_pkg::OFF_ISTAT: begin
                    nx.prdata[1:0] = st.istat;
                    if (pwrite) begin
                        nx.istat = st.istat & ~pwdata[1:0];
                    end
                end
                ua_pkg::OFF_IMASK: begin
                    nx.prdata[1:0] = st.imask;
                    if (pwrite) begin
                        nx.imask = pwdata[1:0];
                    end
                end
                default: begin
                    nx.pslverr = 1'b1;
                end
            endcase
        end
        // receiver: counters only move while running, so a paused word resumes
        if (run) begin
            case (st.rx_st)
                ua_pkg::UA_RX_IDLE: begin
                    if (!st.rx_s2 && st.ctrl2[ua_pkg::C2_RX_EN]
                            && st.ctrl1[ua_pkg::C1_UART_EN]) begin
                        nx.rx_st = ua_pkg::UA_RX_START;
                        nx.rx_cnt = {1'b0, st.baud[7:1]};
                    end
                end
                ua_pkg::UA_RX_START: begin
                    if (st.rx_cnt != 8'h00) begin
                        nx.rx_cnt = st.rx_cnt - 8'h01;
                    end else if (!st.rx_s2) begin
                        nx.rx_st = ua_pkg::UA_RX_BITS;
                        nx.rx_cnt = st.baud;
                        nx.rx_bit = 4'h0;
                    end else begin
                        // glitch, not a start bit
                        nx.rx_st = ua_pkg::UA_RX_IDLE;
                    end
                end
                ua_pkg::UA_RX_BITS: begin
                    if (st.rx_cnt != 8'h00) begin
                        nx.rx_cnt = st.rx_cnt - 8'h01;
                    end else begin
                        nx.rx_shift[st.rx_bit] = st.rx_s2;
                        nx.rx_cnt = st.baud;
                        if (st.rx_bit == nbits - 4'h1) begin
                            nx.rx_st = ua_pkg::UA_RX_STOP;
                        end else begin
                            nx.rx_bit = st.rx_bit + 4'h1;
                        end
                    end
                end
                ua_pkg::UA_RX_STOP: begin
                    if (st.rx_cnt != 8'h00) begin
                        nx.rx_cnt = st.rx_cnt - 8'h01;
                    end else begin
                        word_done = 1'b1;
                        nx.rx_st = ua_pkg::UA_RX_IDLE;
                    end
                end
                default: begin
                    nx.rx_st = ua_pkg::UA_RX_IDLE;
                end
            endcase
        end
        // word delivered; parity bit is not checked here
        if (word_done) begin
            // [RULE_15] unread data flag, set beats read clear
            nx.rx_avail = 1'b1;
            nx.rx_data = rd9;
            // [RULE_03] remember address words
            nx.rx_addr = rx_top;
            // [RULE_01] qualify in address mode
            // [RULE_04] otherwise every word counts
            if (st.ctrl2[ua_pkg::C2_RX_IRQ]
                    && (!st.ctrl2[ua_pkg::C2_ADDR_DET] || rx_top)) begin
                nx.istat[ua_pkg::IS_RX] = 1'b1;
            end
        end
        // transmitter, frozen while paused
        if (run && st.tx_st == ua_pkg::UA_TX_SEND) begin
            if (st.tx_cnt != 8'h00) begin
                nx.tx_cnt = st.tx_cnt - 8'h01;
            end else if (st.tx_bit == 4'h0) begin
                nx.tx_st = ua_pkg::UA_TX_IDLE;
                nx.tx_pin = 1'b1;
            end else begin
                nx.tx_pin = st.tx_shift[0];
                nx.tx_shift = {1'b1, st.tx_shift[11:1]};
                nx.tx_bit = st.tx_bit - 4'h1;
                nx.tx_cnt = st.baud;
            end
        end
        // [RULE_11] falling rx edge while clock off requests wake
        // [RULE_13] wake pulse does not depend on the irq_en enables, though it needs C2_RX_IRQ
        nx.wake_req = 1'b0;
        if (wake_arm && rx_fall) begin
            nx.wake_req = 1'b1;
            nx.wake_seen = 1'b1;
            nx.istat[ua_pkg::IS_WAKE] = 1'b1;
        end
        // start-up interval runs once the clock returns after a wake
        if (st.ck_s2 && !st.ck_s3 && st.wake_seen) begin
            nx.start_cnt = ua_pkg::STARTUP_CYC;
            nx.wake_seen = 1'b0;
        end else if (st.ck_s2 && st.start_cnt != 8'h00) begin
            nx.start_cnt = st.start_cnt - 8'h01;
        end
        // [RULE_12] hold receiver idle, the waking edge is not a start bit
        if (nx.start_cnt != 8'h00) begin
            nx.rx_st = ua_pkg::UA_RX_IDLE;
        end
        // [RULE_05] both enables gate the interrupt
        // [RULE_14] nothing from wake until start-up ends
        // [RULE_16] both sources feed one shared request
        // next-state terms, so irq drops at the very edge the hold begins
        nx.irq = st.irq_en[ua_pkg::IE_SERIAL] && st.irq_en[ua_pkg::IE_GLOBAL]
            && !nx.wake_seen && nx.start_cnt == 8'h00 && |(st.istat & st.imask);
    end

    // state register; sleep has no reset path so settings survive it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.baud <= ua_pkg::BAUD_RST;
            st.tx_pin <= 1'b1;
            st.tx_shift <= 12'hfff;
        end else begin
            st <= nx;
        end
    end

    // outputs straight from the state flops
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign tx_pin = st.tx_pin;
    assign irq = st.irq;
    assign wake_req = st.wake_req;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    addr_filter_a: assert property ( // [RULE_01]
        word_done && st.ctrl2[ua_pkg::C2_ADDR_DET] && !rx_top && !st.istat[ua_pkg::IS_RX]
        |=> !st.istat[ua_pkg::IS_RX])
    else $error("data word raised receive event in address mode");

    ninth_bit_a: assert property ( // [RULE_02]
        word_done && st.ctrl1[ua_pkg::C1_NINE_BIT] && st.rx_shift[8]
        && st.ctrl2[ua_pkg::C2_RX_IRQ] |=> st.istat[ua_pkg::IS_RX] && st.rx_addr)
    else $error("ninth bit high did not qualify");

    rx_every_a: assert property ( // [RULE_04]
        word_done && !st.ctrl2[ua_pkg::C2_ADDR_DET] && st.ctrl2[ua_pkg::C2_RX_IRQ]
        |=> st.istat[ua_pkg::IS_RX])
    else $error("word without address mode lost its event");

    irq_gate_a: assert property ( // [RULE_05]
        st.irq |-> $past(st.irq_en) == 2'h3)
    else $error("interrupt without both enables");

    pause_hold_a: assert property ( // [RULE_07]
        !run && !acc |=> $stable(st.rx_cnt) && $stable(st.tx_cnt) && $stable(st.tx_pin))
    else $error("uart engines moved while paused");

    wake_edge_a: assert property ( // [RULE_11]
        wake_arm && rx_fall |=> st.wake_req ##1 !st.wake_req)
    else $error("armed falling edge gave no single wake pulse");

    startup_rx_a: assert property ( // [RULE_12]
        st.start_cnt != 8'h00 |-> st.rx_st == ua_pkg::UA_RX_IDLE)
    else $error("receiver active during start-up");

    startup_irq_a: assert property ( // [RULE_14]
        (st.wake_seen || st.start_cnt != 8'h00) |-> !st.irq)
    else $error("interrupt during start-up interval");

    avail_set_a: assert property ( // [RULE_15]
        word_done |=> st.rx_avail && st.rx_data == $past(rd9))
    else $error("received word not flagged available");
endmodule

//--- sim/ua_rx_src.sv
// remote serial transmitter model that drives the receive line
`timescale 1ns/1ns
module ua_rx_src (
    input wire logic pclk,
    input wire logic go,
    input wire logic [11:0] frame,
    input wire logic [3:0] len,
    input wire logic [7:0] period,
    output logic rx_pin,
    output logic busy
);
    logic [11:0] sh;
    logic [3:0] left;
    logic [7:0] cnt;

    initial begin
        rx_pin = 1'b1;
        busy = 1'b0;
    end

    // shifts one frame lsb first; the line rests at the idle mark between frames
    always @(posedge pclk) begin
        if (!busy && go) begin
            busy <= 1'b1;
            sh <= frame >> 1;
            rx_pin <= frame[0];
            left <= len - 4'h1;
            cnt <= period - 8'h01;
        end else if (busy && cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end else if (busy && left != 4'h0) begin
            rx_pin <= sh[0];
            sh <= sh >> 1;
            left <= left - 4'h1;
            cnt <= period - 8'h01;
        end else if (busy) begin
            rx_pin <= 1'b1;
            busy <= 1'b0;
        end
    end
endmodule

//--- sim/uart_addr_detect_wakeup_tb.sv
// self-checking bench for address qualification, power-down pause and rx wake-up
`timescale 1ns/1ns
module uart_addr_detect_wakeup_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic uart_clk_on = 1'b1;
    logic cpu_sleep = 1'b0;
    logic go = 1'b0;
    logic [11:0] frame = 12'hfff;
    logic [3:0] len = 4'h1;
    logic [7:0] period = 8'h0a;
    logic [31:0] prdata;
    logic pready, pslverr, rx_pin, tx_pin, irq, wake_req, busy;
    logic [64:0] note;
    logic [64:0] notes[$];
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    int wakes = 0;
    int seed = 32'h38578595;

    ua_addr_wake ua_addr_wake_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
        .uart_clk_on(uart_clk_on), .cpu_sleep(cpu_sleep), .tx_pin(tx_pin),
        .irq(irq), .wake_req(wake_req));
    ua_rx_src ua_rx_src_i (.pclk(pclk), .go(go), .frame(frame), .len(len),
        .period(period), .rx_pin(rx_pin), .busy(busy));

    always #25 pclk = ~pclk;

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // each finished transfer retires the oldest note; a hang ends in the report
    always @(posedge pclk) begin
        cycles++;
        if (wake_req === 1'b1) wakes++;
        if (psel && penable && pready === 1'b1) begin
            note = notes.pop_front();
            check({pslverr, prdata & note[63:32]}, {note[64], note[31:0]});
        end
        if (cycles == 40000) begin
            failures++;
            stop_test();
        end
    end

    // one apb transfer: setup, access held until pready, note queued first
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic [31:0] e, input logic err);
        notes.push_back({err, m, e});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0, m, e, 1'b0);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // hands one frame to the line model and waits until the whole frame has gone out on the wire
    task automatic send(input logic [11:0] f, input logic [3:0] n, input logic [7:0] p);
        @(posedge pclk);
        frame <= f;
        len <= n;
        period <= p;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        @(posedge pclk);
        while (busy) @(posedge pclk);
    endtask

    initial begin
        logic [8:0] w;
        logic nine, ad, q;
        tick(5);
        presetn <= 1'b1;
        tick(4);
        // reset values, an unmapped place and a write to the read-only status
        rd(ua_pkg::OFF_CTRL2, 32'hffffffff, 32'h0);
        rd(ua_pkg::OFF_BAUD, 32'hffffffff, 32'h9);
        rd(ua_pkg::OFF_IMASK, 32'hffffffff, 32'h0);
        apb(1'b0, 8'h20, 32'h0, 32'h0, 32'h0, 1'b1);
        wr(ua_pkg::OFF_STATUS, 32'hffffffff);
        rd(ua_pkg::OFF_STATUS, 32'h1, 32'h0);
        wr(ua_pkg::OFF_IRQEN, 32'h3);
        wr(ua_pkg::OFF_IMASK, 32'h1);
        // word length and address mode table; the lower bits are random
        for (int i = 0; i < 6; i++) begin
            nine = i > 3;
            ad = i > 1;
            w = 9'($random(seed));
            if (nine) w[8:7] = {i[0], ~i[0]};
            else w[8:7] = {1'b0, i[0]};
            q = !ad || i[0];
            wr(ua_pkg::OFF_CTRL1, {28'h0, nine, 3'b011});
            wr(ua_pkg::OFF_CTRL2, {28'h0, 3'b110, ad});
            send(nine ? {2'b11, w, 1'b0} : {3'b111, w[7:0], 1'b0}, nine ? 4'hb : 4'ha, 8'h0a);
            tick(20);
            check({32'h0, irq}, {32'h0, q});
            rd(ua_pkg::OFF_ISTAT, 32'h1, {31'h0, q});
            if (i == 5) begin
                wr(ua_pkg::OFF_IRQEN, 32'h1);
                tick(2);
                check({32'h0, irq}, 33'h0);
                wr(ua_pkg::OFF_IRQEN, 32'h3);
            end
            // address flag follows the top bit; receiver idle, word available
            rd(ua_pkg::OFF_STATUS, 32'h1f, {27'h0, i[0], 4'h3});
            rd(ua_pkg::OFF_DATA, 32'h1ff, {23'h0, nine ? w : {1'b0, w[7:0]}});
            rd(ua_pkg::OFF_STATUS, 32'h1, 32'h0);
            wr(ua_pkg::OFF_ISTAT, 32'h3);
        end
        // transmit frozen while asleep, registers untouched by the sleep
        wr(ua_pkg::OFF_DATA, 32'h55);
        tick(30);
        cpu_sleep <= 1'b1;
        tick(3);
        q = tx_pin;
        tick(60);
        check({32'h0, tx_pin}, {32'h0, q});
        rd(ua_pkg::OFF_STATUS, 32'h4, 32'h4);
        rd(ua_pkg::OFF_CTRL1, 32'hf, 32'hb);
        rd(ua_pkg::OFF_BAUD, 32'hff, 32'h9);
        cpu_sleep <= 1'b0;
        tick(150);
        rd(ua_pkg::OFF_STATUS, 32'h4, 32'h0);
        // wake edge with interrupts off, then on, then the start-up interval
        wr(ua_pkg::OFF_IRQEN, 32'h0);
        wr(ua_pkg::OFF_IMASK, 32'h2);
        wr(ua_pkg::OFF_CTRL2, 32'he);
        uart_clk_on <= 1'b0;
        tick(8);
        send(12'hffe, 4'h1, 8'h0a);
        tick(5);
        check(33'(wakes), 33'h1);
        check({32'h0, irq}, 33'h0);
        rd(ua_pkg::OFF_ISTAT, 32'h2, 32'h2);
        wr(ua_pkg::OFF_ISTAT, 32'h3);
        wr(ua_pkg::OFF_IRQEN, 32'h3);
        send(12'hffe, 4'h1, 8'h0a);
        tick(5);
        check(33'(wakes), 33'h2);
        // the wake event is pending but held back until start-up is over
        check({32'h0, irq}, 33'h0);
        uart_clk_on <= 1'b1;
        tick(5);
        check({32'h0, irq}, 33'h0);
        send(12'h2aa, 4'ha, 8'h01);
        check({32'h0, irq}, 33'h0);
        tick(30);
        check({32'h0, irq}, 33'h1);
        tick(100);
        rd(ua_pkg::OFF_STATUS, 32'h1, 32'h0);
        stop_test();
    end
endmodule
